// file: include/ppfl_pkg.sv
package ppfl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int DW = 16;
  localparam int AW = 4;
  localparam logic [AW-1:0] OFS_BIT_LATCH = 4'h0;
  localparam logic [AW-1:0] OFS_BIT_PP    = 4'h1;
  localparam logic [AW-1:0] OFS_BIT_PU    = 4'h2;
  localparam logic [AW-1:0] OFS_BIT_KW    = 4'h3;
  localparam logic [AW-1:0] OFS_BIT_PIN   = 4'h4;
  localparam logic [AW-1:0] OFS_QD_LATCH  = 4'h5;
  localparam logic [AW-1:0] OFS_QD_PU     = 4'h6;
  localparam logic [AW-1:0] OFS_QD_KW     = 4'h7;
  localparam logic [AW-1:0] OFS_QD_CFG    = 4'h8;
  localparam logic [AW-1:0] OFS_QD_PIN    = 4'h9;
  localparam logic [AW-1:0] OFS_MISC      = 4'ha;
  localparam logic [AW-1:0] OFS_IRQ_STAT  = 4'hb;
  localparam logic [AW-1:0] OFS_IRQ_MASK  = 4'hc;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int MISC_PORTC  = 0;
  localparam int MISC_PWMSEL = 1;
  localparam int MISC_TMRIN  = 2;
  localparam int MISC_INTKW  = 3;
  localparam int MISC_INTPOL = 4;
  localparam int MISC_SUBCLK = 5;
  localparam int MISC_DUTY   = 6;
  localparam logic [1:0] DUTY_HALF    = 2'h1;
  localparam logic [1:0] DUTY_THIRD   = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;
  localparam int IRQ_EXTINT = 0;
  localparam int IRQ_KEYWK  = 1;
  localparam int IRQ_RESET  = 2;
  localparam int SY_TIMER = 0;
  localparam int SY_VDEN  = 1;
  localparam int SY_POR   = 2;
  localparam int SY_VDRST = 3;
  localparam logic [7:0]  BIT_LATCH_RST = 8'hff;
  localparam logic [15:0] QD_LATCH_RST  = 16'hffff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_HOLD_NS   = 100;
  localparam int RST_HOLD_CYC  =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ppfl_req_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oeN;
  } ppfl_drv8_type;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oeN;
  } ppfl_drv16_type;

  typedef struct packed {
    logic [7:0]    bitLatch;
    logic [5:0]    bitPp;
    logic [7:0]    bitPu;
    logic [7:0]    bitKw;
    logic [15:0]   qdLatch;
    logic [15:0]   qdPu;
    logic [15:0]   qdKw;
    logic [3:0]    qdPp;
    logic [3:0]    segSel;
    logic [7:0]    misc;
    logic [2:0]    irqStat;
    logic [2:0]    irqMask;
    logic [7:0]    s1Bit;
    logic [7:0]    s2Bit;
    logic [15:0]   s1Qd;
    logic [15:0]   s2Qd;
    logic [3:0]    s1Misc;
    logic [3:0]    s2Misc;
    logic          intPrev;
    logic [4:0]    rstCnt;
    ppfl_drv8_type  bitDrv;
    ppfl_drv16_type qdDrv;
    logic [7:0]    bitPuEn;
    logic [15:0]   qdPuEn;
    logic          tmrOut;
    logic          tmrOeN;
    logic          tmrCount;
    logic          rstOeN;
    logic          vdRun;
    logic [3:0]    comEn;
    logic          subclkEn;
    logic          wake;
    logic          irq;
    logic [DW-1:0] rdata;
  } ppfl_state_type;

endpackage

// file: src/ppfl_port_pins.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - Bit port pins are independent; pins 0-5 select open-drain or push-pull.
// - Bit pins 6 and 7 are always open-drain and serve the sub-clock.
// - Every bit and nibble pin has switchable pull-up and key wakeup.
// - Each nibble port is 4-bit I/O with selectable open-drain or push-pull.
// - Nibble pins carry segments 16 to 31 in order, port zero first.
// - Single-bit output port is push-pull and shares the timer pin.
// - Timer pin feeds timer 1 count clock in, timer 2 PWM out.
// - Interrupt pin shares bit 5, takes requests, has switchable wakeup.
// - Reset pin is driven low on any system reset cause.
// - Voltage-drop detector runs while its enable pin is high.
// - Common outputs in use follow the selected duty.
module ppfl_port_pins
  import ppfl_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           arst_n,
  input  wire ppfl_req_type   busReq,
  output logic [DW-1:0]       busRdata,
  input  wire logic [7:0]     bitPortIn,
  output ppfl_drv8_type       bitPortDrv,
  output logic [7:0]          bitPullupEn,
  input  wire logic [15:0]    quadPortIn,
  output ppfl_drv16_type      quadPortDrv,
  output logic [15:0]         quadPullupEn,
  input  wire logic [15:0]    lcdSegmentOutput,
  input  wire logic           timerIoPinIn,
  output logic                timerIoPinOut,
  output logic                timerIoPinOeN,
  input  wire logic           timer2Pwm,
  output logic                timer1CountClk,
  input  wire logic           softwareResetInstruction,
  input  wire logic           wdtReset,
  input  wire logic           porReset,
  input  wire logic           vdropReset,
  output logic                resetPinOut,
  output logic                resetPinOeN,
  input  wire logic           vdropDetectEnablePin,
  output logic                vdropRun,
  output logic [3:0]          lcdCommonOutputEn,
  output logic                subclockEnable,
  output logic                keyWakeup,
  output logic                irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  ppfl_state_type s, n;

  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic [7:0] ppMask;
  logic [7:0] subMask;
  logic [15:0] segMask;
  logic       d5;
  logic       cause;

  always_comb begin
    n = s;
    irqSet = 3'h0;
    irqClr = 3'h0;
    n.s1Bit = bitPortIn;
    n.s2Bit = s.s1Bit;
    n.s1Qd = quadPortIn;
    n.s2Qd = s.s1Qd;
    n.s1Misc = {vdropReset, porReset, vdropDetectEnablePin, timerIoPinIn};
    n.s2Misc = s.s1Misc;

    // ****************************************************************
    // Register access
    // ****************************************************************
    n.rdata = '0;
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFS_BIT_LATCH: n.rdata = {8'h00, s.bitLatch};
        OFS_BIT_PP:    n.rdata = {10'h0, s.bitPp};
        OFS_BIT_PU:    n.rdata = {8'h00, s.bitPu};
        OFS_BIT_KW:    n.rdata = {8'h00, s.bitKw};
        OFS_BIT_PIN:   n.rdata = {8'h00, s.s2Bit};
        OFS_QD_LATCH:  n.rdata = s.qdLatch;
        OFS_QD_PU:     n.rdata = s.qdPu;
        OFS_QD_KW:     n.rdata = s.qdKw;
        OFS_QD_CFG:    n.rdata = {8'h00, s.segSel, s.qdPp};
        OFS_QD_PIN:    n.rdata = s.s2Qd;
        OFS_MISC:      n.rdata = {8'h00, s.misc};
        OFS_IRQ_STAT:  n.rdata = {13'h0, s.irqStat};
        OFS_IRQ_MASK:  n.rdata = {13'h0, s.irqMask};
        default:       n.rdata = '0;
      endcase
    end
    if (busReq.wr) begin
      unique case (busReq.addr)
        OFS_BIT_LATCH: n.bitLatch = busReq.wdata[7:0];
        OFS_BIT_PP:    n.bitPp = busReq.wdata[5:0];
        OFS_BIT_PU:    n.bitPu = busReq.wdata[7:0];
        OFS_BIT_KW:    n.bitKw = busReq.wdata[7:0];
        OFS_QD_LATCH:  n.qdLatch = busReq.wdata;
        OFS_QD_PU:     n.qdPu = busReq.wdata;
        OFS_QD_KW:     n.qdKw = busReq.wdata;
        OFS_QD_CFG: begin
          n.qdPp = busReq.wdata[3:0];
          n.segSel = busReq.wdata[7:4];
        end
        OFS_MISC:      n.misc = busReq.wdata[7:0];
        OFS_IRQ_STAT:  irqClr = busReq.wdata[2:0];
        OFS_IRQ_MASK:  n.irqMask = busReq.wdata[2:0];
        default: ;
      endcase
    end

    // ****************************************************************
    // Bit-addressable port
    // ****************************************************************
    ppMask = {2'h0, s.bitPp};
    subMask = s.misc[MISC_SUBCLK] ? 8'hc0 : 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (subMask[i]) begin
        n.bitDrv.out[i] = 1'b0;
        n.bitDrv.oeN[i] = 1'b1;
      end else if (ppMask[i]) begin
        n.bitDrv.out[i] = s.bitLatch[i];
        n.bitDrv.oeN[i] = 1'b0;
      end else begin
        n.bitDrv.out[i] = 1'b0;
        n.bitDrv.oeN[i] = s.bitLatch[i];
      end
    end
    n.bitPuEn = s.bitPu & ~subMask;
    n.subclkEn = s.misc[MISC_SUBCLK];

    // ****************************************************************
    // Nibble ports and segment sharing
    // ****************************************************************
    for (int i = 0; i < 16; i++) begin
      segMask[i] = s.segSel[i/4];
      if (segMask[i]) begin
        n.qdDrv.out[i] = lcdSegmentOutput[i];
        n.qdDrv.oeN[i] = 1'b0;
      end else if (s.qdPp[i/4]) begin
        n.qdDrv.out[i] = s.qdLatch[i];
        n.qdDrv.oeN[i] = 1'b0;
      end else begin
        n.qdDrv.out[i] = 1'b0;
        n.qdDrv.oeN[i] = s.qdLatch[i];
      end
    end
    n.qdPuEn = s.qdPu & ~segMask;

    // ****************************************************************
    // Key wakeup and external interrupt
    // ****************************************************************
    d5 = s.s2Bit[5];
    n.intPrev = d5;
    if (s.misc[MISC_INTPOL] ? (d5 && !s.intPrev)
                            : (!d5 && s.intPrev)) begin
      irqSet[IRQ_EXTINT] = 1'b1;
    end
    n.wake = (|(s.bitKw & ~s.s2Bit & ~subMask))
           | (|(s.qdKw & ~s.s2Qd & ~segMask))
           | (s.misc[MISC_INTKW]
              && (d5 == s.misc[MISC_INTPOL]));
    irqSet[IRQ_KEYWK] = n.wake;

    // ****************************************************************
    // Timer pin
    // ****************************************************************
    n.tmrOut = s.misc[MISC_PWMSEL] ? (timer2Pwm | s.misc[MISC_PORTC])
                                   : s.misc[MISC_PORTC];
    n.tmrOeN = s.misc[MISC_TMRIN];
    n.tmrCount = s.misc[MISC_TMRIN] & s.s2Misc[SY_TIMER];

    // ****************************************************************
    // Reset pin, detector enable, commons
    // ****************************************************************
    cause = softwareResetInstruction | wdtReset
          | s.s2Misc[SY_POR] | s.s2Misc[SY_VDRST];
    if (cause) begin
      n.rstCnt = 5'(RST_HOLD_CYC);
    end else if (s.rstCnt != 5'h00) begin
      n.rstCnt = s.rstCnt - 5'h01;
    end
    n.rstOeN = !(cause || s.rstCnt != 5'h00);
    irqSet[IRQ_RESET] = cause;
    n.vdRun = s.s2Misc[SY_VDEN];
    unique case (s.misc[MISC_DUTY +: 2])
      DUTY_HALF:    n.comEn = 4'h3;
      DUTY_THIRD:   n.comEn = 4'h7;
      DUTY_QUARTER: n.comEn = 4'hf;
      default:      n.comEn = 4'h0;
    endcase

    // A new event wins over a clear in the same cycle.
    n.irqStat = (s.irqStat & ~irqClr) | irqSet;
    n.irq = |(n.irqStat & n.irqMask);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.bitLatch <= BIT_LATCH_RST;
      s.qdLatch <= QD_LATCH_RST;
      s.bitDrv.oeN <= 8'hff;
      s.qdDrv.oeN <= 16'hffff;
      s.tmrOeN <= 1'b0;
      s.rstOeN <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign busRdata = s.rdata;
  assign bitPortDrv = s.bitDrv;
  assign bitPullupEn = s.bitPuEn;
  assign quadPortDrv = s.qdDrv;
  assign quadPullupEn = s.qdPuEn;
  assign timerIoPinOut = s.tmrOut;
  assign timerIoPinOeN = s.tmrOeN;
  assign timer1CountClk = s.tmrCount;
  assign resetPinOut = s.rstCnt[4] & 1'b0;
  assign resetPinOeN = s.rstOeN;
  assign vdropRun = s.vdRun;
  assign lcdCommonOutputEn = s.comEn;
  assign subclockEnable = s.subclkEn;
  assign keyWakeup = s.wake;
  assign irq = s.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence q_cause;
    softwareResetInstruction || wdtReset;
  endsequence
  sequence q_hold;
    !resetPinOeN [*8];
  endsequence

  property p_hiNeverDriven;
    @(posedge core_clk) disable iff (!arst_n)
      !(!bitPortDrv.oeN[7] && bitPortDrv.out[7])
      && !(!bitPortDrv.oeN[6] && bitPortDrv.out[6]);
  endproperty
  a_hiNeverDriven: assert property (p_hiNeverDriven)
    else $error("Bit pin 6 or 7 drove high.");

  property p_pushPull0;
    @(posedge core_clk) disable iff (!arst_n)
      (s.bitPp[0] && !s.misc[MISC_SUBCLK]) |=>
        (!bitPortDrv.oeN[0] && bitPortDrv.out[0] == $past(s.bitLatch[0]));
  endproperty
  a_pushPull0: assert property (p_pushPull0)
    else $error("Push-pull bit 0 did not follow its latch.");

  property p_quadOd;
    @(posedge core_clk) disable iff (!arst_n)
      (!s.segSel[1] && !s.qdPp[1]) |=>
        (quadPortDrv.out[7:4] == 4'h0
         && quadPortDrv.oeN[7:4] == $past(s.qdLatch[7:4]));
  endproperty
  a_quadOd: assert property (p_quadOd)
    else $error("Open-drain nibble port one misdriven.");

  property p_segMap;
    @(posedge core_clk) disable iff (!arst_n)
      s.segSel[3] |=>
        (quadPortDrv.out[15:12] == $past(lcdSegmentOutput[15:12])
         && quadPortDrv.oeN[15:12] == 4'h0);
  endproperty
  a_segMap: assert property (p_segMap)
    else $error("Segments 28 to 31 not on nibble port three.");

  property p_pwm;
    @(posedge core_clk) disable iff (!arst_n)
      s.misc[MISC_PWMSEL] |=>
        timerIoPinOut == ($past(timer2Pwm) | $past(s.misc[MISC_PORTC]));
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("Timer pin did not carry the PWM wave.");

  property p_resetHold;
    @(posedge core_clk) disable iff (!arst_n)
      q_cause |=> q_hold;
  endproperty
  a_resetHold: assert property (p_resetHold)
    else $error("Reset pin released too early.");

  property p_vdrop;
    @(posedge core_clk) disable iff (!arst_n)
      1'b1 |=> vdropRun == $past(s.s2Misc[SY_VDEN]);
  endproperty
  a_vdrop: assert property (p_vdrop)
    else $error("Detector run did not follow its enable pin.");

  property p_duty;
    @(posedge core_clk) disable iff (!arst_n)
      (s.misc[MISC_DUTY +: 2] == DUTY_THIRD) |=> lcdCommonOutputEn == 4'h7;
  endproperty
  a_duty: assert property (p_duty)
    else $error("Third duty did not select commons 0 to 2.");

  property p_extInt;
    @(posedge core_clk) disable iff (!arst_n)
      (s.misc[MISC_INTPOL] && s.s2Bit[5] && !s.intPrev)
        |=> s.irqStat[IRQ_EXTINT];
  endproperty
  a_extInt: assert property (p_extInt)
    else $error("Interrupt pin edge was lost.");

  property p_readPins;
    @(posedge core_clk) disable iff (!arst_n)
      (busReq.rd && busReq.addr == OFS_QD_PIN) |=>
        busRdata == $past(s.s2Qd);
  endproperty
  a_readPins: assert property (p_readPins)
    else $error("Nibble pin read returned a wrong level.");

endmodule

// file: tb/ppfl_board.sv
`timescale 1ns/100ps
module ppfl_board
  import ppfl_pkg::*;
(
  input  wire logic           core_clk,
  input  wire ppfl_drv8_type  bitDrv,
  input  wire logic [7:0]     bitPu,
  input  wire ppfl_drv16_type quadDrv,
  input  wire logic [15:0]    quadPu,
  input  wire logic [7:0]     keyBit,
  input  wire logic [15:0]    keyQuad,
  output logic [7:0]          bitPin,
  output logic [15:0]         quadPin
);
  // ****************************************************************
  // Pin resolution
  // ****************************************************************
  logic floatLvl_r = 1'b0;

  // A released pin without pull-up toggles its level every clock, so reads of it are unreliable.
  always @(posedge core_clk) begin
    floatLvl_r <= ~floatLvl_r;
  end

  // A pressed key grounds the pin; otherwise driver, pull-up, then float.
  function automatic logic lvl(input logic oeN, out, key, pu, flt);
    if (key) return 1'b0;
    if (!oeN) return out;
    if (pu) return 1'b1;
    return flt;
  endfunction

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bitPin[i] = lvl(bitDrv.oeN[i], bitDrv.out[i], keyBit[i], bitPu[i],
                      floatLvl_r);
    end
    for (int i = 0; i < 16; i++) begin
      quadPin[i] = lvl(quadDrv.oeN[i], quadDrv.out[i], keyQuad[i],
                       quadPu[i], floatLvl_r);
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
  import ppfl_pkg::*;
;
  logic           core_clk = 1'b0;
  logic           arst_n;
  ppfl_req_type   busReq;
  logic [15:0]    busRdata, quadPu, quadPin, keyQuad, lcd_segment_output, rv;
  ppfl_drv8_type  bitDrv;
  ppfl_drv16_type quadDrv;
  logic [7:0]     bitPu, bitPin, keyBit;
  logic [3:0]     cause, comEn;
  logic           tmrIn, tmrOut, tmrOeN, pwm, cntClk, rstOut, rstOeN;
  logic           vdEn, vdRun, subEn, wake, irq;
  int             checks_done, mismatches;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  ppfl_port_pins i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .busReq(busReq), .busRdata(busRdata), .bitPortIn(bitPin),
    .bitPortDrv(bitDrv), .bitPullupEn(bitPu), .quadPortIn(quadPin),
    .quadPortDrv(quadDrv), .quadPullupEn(quadPu), .lcdSegmentOutput(lcd_segment_output),
    .timerIoPinIn(tmrIn), .timerIoPinOut(tmrOut), .timerIoPinOeN(tmrOeN),
    .timer2Pwm(pwm), .timer1CountClk(cntClk),
    .softwareResetInstruction(cause[0]), .wdtReset(cause[1]),
    .porReset(cause[2]), .vdropReset(cause[3]), .resetPinOut(rstOut),
    .resetPinOeN(rstOeN), .vdropDetectEnablePin(vdEn), .vdropRun(vdRun),
    .lcdCommonOutputEn(comEn), .subclockEnable(subEn), .keyWakeup(wake),
    .irq(irq));

  ppfl_board i_board (.core_clk(core_clk), .bitDrv(bitDrv), .bitPu(bitPu),
    .quadDrv(quadDrv), .quadPu(quadPu), .keyBit(keyBit),
    .keyQuad(keyQuad), .bitPin(bitPin), .quadPin(quadPin));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge core_clk);
    busReq <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    busReq <= '0;
  endtask

  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    busReq <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    busReq <= '0;
    #1;
    d = busRdata;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(OFS_BIT_LATCH, rv);
    chk("bit latch", rv, 16'h00ff);
    rd(OFS_QD_LATCH, rv);
    chk("quad latch", rv, 16'hffff);
    rd(4'hd, rv);
    chk("unmapped", rv, 16'h0000);
    chk("bit oeN", bitDrv.oeN, 16'h00ff);
    chk("reset pin oeN", rstOeN, 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_bitport;
    wr(OFS_BIT_PU, 16'h00ff);
    wr(OFS_BIT_PP, 16'h00ff);
    wr(OFS_BIT_LATCH, 16'h0055);
    cyc(2);
    chk("bit oeN", bitDrv.oeN, 16'h0040);
    chk("bit out", bitDrv.out & ~bitDrv.oeN, 16'h0015);
    cyc(4);
    rd(OFS_BIT_PIN, rv);
    chk("bit pins", rv, 16'h0055);
    $display("test bitport done");
  endtask

  task automatic t_keywake;
    wr(OFS_BIT_PP, 16'h0000);
    wr(OFS_BIT_LATCH, 16'h00ff);
    wr(OFS_IRQ_MASK, 16'h0000);
    wr(OFS_BIT_KW, 16'h0008);
    keyBit <= 8'h08;
    cyc(6);
    rd(OFS_BIT_PIN, rv);
    chk("bit pins", rv, 16'h00f7);
    chk("wake", wake, 16'h0001);
    chk("irq masked", irq, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0002);
    cyc(2);
    chk("irq", irq, 16'h0001);
    keyBit <= 8'h00;
    cyc(6);
    chk("wake off", wake, 16'h0000);
    wr(OFS_IRQ_STAT, 16'h0002);
    cyc(2);
    chk("irq cleared", irq, 16'h0000);
    wr(OFS_BIT_KW, 16'h0000);
    $display("test keywake done");
  endtask

  task automatic t_extint;
    keyBit <= 8'h20;
    cyc(6);
    wr(OFS_MISC, 16'h0010);
    wr(OFS_IRQ_STAT, 16'h0007);
    wr(OFS_IRQ_MASK, 16'h0001);
    cyc(2);
    chk("int idle", irq, 16'h0000);
    keyBit <= 8'h00;
    cyc(6);
    chk("int irq", irq, 16'h0001);
    rd(OFS_IRQ_STAT, rv);
    chk("int stat", rv & 16'h0001, 16'h0001);
    wr(OFS_MISC, 16'h0018);
    cyc(3);
    chk("int wake", wake, 16'h0001);
    wr(OFS_MISC, 16'h0000);
    wr(OFS_IRQ_STAT, 16'h0007);
    keyBit <= 8'h20;
    cyc(6);
    chk("int fall", irq, 16'h0001);
    keyBit <= 8'h00;
    cyc(6);
    wr(OFS_IRQ_STAT, 16'h0007);
    $display("test extint done");
  endtask

  task automatic t_quad;
    wr(OFS_QD_PU, 16'hffff);
    wr(OFS_QD_LATCH, 16'h3c5a);
    lcd_segment_output <= 16'h9000;
    wr(OFS_QD_CFG, 16'h0081);
    cyc(3);
    chk("quad oeN", quadDrv.oeN, 16'h0c50);
    chk("quad out", quadDrv.out & ~quadDrv.oeN, 16'h900a);
    chk("quad pu", quadPu, 16'h0fff);
    cyc(4);
    rd(OFS_QD_PIN, rv);
    chk("quad pins", rv, 16'h9c5a);
    lcd_segment_output <= 16'hc35a;
    for (int p = 0; p < 4; p++) begin
      wr(OFS_QD_CFG, 16'h0010 << p);
      cyc(3);
      chk("seg out", (quadDrv.out >> (4 * p)) & 16'h000f,
          (lcd_segment_output >> (4 * p)) & 16'h000f);
      chk("seg oeN", (quadDrv.oeN >> (4 * p)) & 16'h000f, 16'h0000);
    end
    wr(OFS_QD_CFG, 16'h0000);
    wr(OFS_QD_KW, 16'h0002);
    keyQuad <= 16'h0002;
    cyc(6);
    chk("quad wake", wake, 16'h0001);
    keyQuad <= 16'h0000;
    cyc(6);
    chk("quad wake off", wake, 16'h0000);
    wr(OFS_QD_KW, 16'h0000);
    $display("test quad done");
  endtask

  task automatic t_timer;
    pwm <= 1'b1;
    wr(OFS_MISC, 16'h0002);
    cyc(3);
    chk("pwm high", {tmrOut, tmrOeN}, 16'h0002);
    pwm <= 1'b0;
    cyc(3);
    chk("pwm low", tmrOut, 16'h0000);
    wr(OFS_MISC, 16'h0003);
    cyc(3);
    chk("pwm or latch", tmrOut, 16'h0001);
    wr(OFS_MISC, 16'h0004);
    tmrIn <= 1'b1;
    cyc(5);
    chk("count in", {cntClk, tmrOeN}, 16'h0003);
    tmrIn <= 1'b0;
    cyc(5);
    chk("count low", cntClk, 16'h0000);
    wr(OFS_MISC, 16'h0001);
    cyc(3);
    chk("port c", {tmrOut, tmrOeN}, 16'h0002);
    $display("test timer done");
  endtask

  task automatic t_rstpin;
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      cause <= 4'h1 << c;
      cyc(5);
      chk("reset low", {rstOut, rstOeN}, 16'h0000);
      cause <= 4'h0;
      cyc(RST_HOLD_CYC + 8);
      chk("reset free", rstOeN, 16'h0001);
      rd(OFS_IRQ_STAT, rv);
      chk("reset stat", rv & 16'h0004, 16'h0004);
      wr(OFS_IRQ_STAT, 16'h0004);
    end
    $display("test rstpin done");
  endtask

  task automatic t_misc;
    vdEn <= 1'b1;
    cyc(5);
    chk("vdrop run", vdRun, 16'h0001);
    vdEn <= 1'b0;
    cyc(5);
    chk("vdrop stop", vdRun, 16'h0000);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_MISC, 16'(d) << MISC_DUTY);
      cyc(3);
      chk("commons", comEn, (d == 0) ? 16'h0 : (16'h1 << (d + 1)) - 1);
    end
    wr(OFS_MISC, 16'h0020);
    cyc(3);
    chk("subclock", {subEn, bitDrv.oeN[7:6], bitPu[7:6]}, 16'h001c);
    $display("test misc done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    checks_done = 0;
    mismatches = 0;
    arst_n = 1'b0;
    busReq = '0;
    keyBit = 8'h00;
    keyQuad = 16'h0000;
    lcd_segment_output = 16'h0000;
    tmrIn = 1'b0;
    pwm = 1'b0;
    cause = 4'h0;
    vdEn = 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_bitport();
    t_keywake();
    t_extint();
    t_quad();
    t_timer();
    t_rstpin();
    t_misc();
    test_done();
  end

  initial begin
    #(20000 * CLK_PERIOD_NS);
    mismatches++;
    test_done();
  end
endmodule
